// ---- hdl/rlf_pkg.sv ----
// Package for the regulator low-power, fault mask and fuse control words.
// Assumes a 16-bit register port with 8-bit register addresses.
package rlf_pkg;
  // Register addresses
  localparam logic [7:0] RLF_ADDR_REG4_LP = 8'hD3;
  localparam logic [7:0] RLF_ADDR_FAULT_MASK = 8'hD7;
  localparam logic [7:0] RLF_ADDR_FUSE_CTRL = 8'hD8;
  // Field positions
  localparam int RLF_ACT_LSB = 12;
  localparam int RLF_SRC_LSB = 8;
  localparam int RLF_VCODE_LSB = 0;
  localparam int RLF_LS_BIT = 15;
  localparam int RLF_LDO_LSB = 8;
  localparam int RLF_DC_LSB = 0;
  localparam int RLF_FUSE_BIT = 15;
  // Manufacture defaults
  localparam logic [1:0] RLF_ACT_RST = 2'h0;
  localparam logic [1:0] RLF_SRC_RST = 2'h0;
  localparam logic [4:0] RLF_VCODE_RST = 5'h1C;
  localparam logic [15:0] RLF_MASK_RST = 16'h0000;
  // Writable bits of the mask word
  localparam logic [15:0] RLF_MASK_BITS = 16'h8F3F;
  typedef enum logic [1:0] {
    RLF_ACT_IMAGE = 2'b00,
    RLF_ACT_DISABLE = 2'b01,
    RLF_ACT_RSVD2 = 2'b10,
    RLF_ACT_RSVD3 = 2'b11
  } rlf_action_t;
  typedef enum logic [1:0] {
    RLF_SRC_REGBIT = 2'b00,
    RLF_SRC_LINE1 = 2'b01,
    RLF_SRC_LINE2 = 2'b10,
    RLF_SRC_LINE3 = 2'b11
  } rlf_source_t;
  // Image voltage in millivolts: 100mV steps from 1.8V, 50mV from 0.9V
  localparam int RLF_HI_BASE_MV = 1800;
  localparam int RLF_HI_STEP_MV = 100;
  localparam int RLF_LO_BASE_MV = 900;
  localparam int RLF_LO_STEP_MV = 50;
endpackage

// ---- hdl/rlf_regs.sv ----
// Control words: regulator four sleep setup, supply-fault masks, fuse current.
// Assumes fault inputs and low-power lines are asynchronous pins.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module rlf_regs
  import rlf_pkg::*;
(
  // Clock and synchronous register reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // Register port
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  output logic [15:0] RDATA_OUT,
  // Sleep trigger sources
  input wire logic SLEEP_REG_BIT_IN,
  input wire logic LOW_POWER_LINE_ONE_IN,
  input wire logic LOW_POWER_LINE_TWO_IN,
  input wire logic LOW_POWER_LINE_THREE_IN,
  // Fault sources
  input wire logic LIMIT_SWITCH_FAULT_IN,
  input wire logic [3:0] LINEAR_REG_FAULT_IN,
  input wire logic [5:0] CONVERTER_FAULT_IN,
  // Regulator four sleep controls
  output logic REG4_SLEEP_OUT,
  output logic REG4_SLEEP_DISABLE_OUT,
  output logic REG4_SLEEP_IMAGE_OUT,
  output logic [4:0] REG4_SLEEP_VOLTAGE_CODE_OUT,
  output logic [11:0] REG4_IMAGE_MV_OUT,
  // Supply fault and fuse current
  output logic SUPPLY_FAULT_N_OUT,
  output logic TRIM_FUSE_CURRENT_ENABLE_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Millivolts for a voltage code
  function automatic logic [11:0] code_to_mv(input logic [4:0] code);
    logic [11:0] step;
    step = {8'h00, code[3:0]};
    if (code[4]) begin
      code_to_mv = 12'(RLF_HI_BASE_MV) + 12'(step * 12'(RLF_HI_STEP_MV));
    end else begin
      code_to_mv = 12'(RLF_LO_BASE_MV) + 12'(step * 12'(RLF_LO_STEP_MV));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two stages each
  logic [14:0] sync1, sync2;
  logic [14:0] pins;
  assign pins = {LINEAR_REG_FAULT_IN, CONVERTER_FAULT_IN, LIMIT_SWITCH_FAULT_IN,
                 SLEEP_REG_BIT_IN, LOW_POWER_LINE_ONE_IN,
                 LOW_POWER_LINE_TWO_IN, LOW_POWER_LINE_THREE_IN};
  always_ff @(posedge REF_CLK_IN) begin
    sync1 <= pins;
    sync2 <= sync1;
  end
  logic [3:0] ldo_flt;
  logic [5:0] dc_flt;
  logic ls_flt, src_reg, src_l1, src_l2, src_l3;
  assign {ldo_flt, dc_flt, ls_flt, src_reg, src_l1, src_l2, src_l3} = sync2;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  rlf_action_t reg4_sleep_action, next_reg4_sleep_action;
  rlf_source_t reg4_sleep_source_sel, next_reg4_sleep_source_sel;
  logic [4:0] reg4_sleep_voltage_code, next_reg4_sleep_voltage_code;
  logic [15:0] fault_mask, next_fault_mask;
  logic trim_fuse_current_enable, next_trim_fuse_current_enable;
  logic [15:0] rdata, next_rdata;

  always_comb begin
    next_reg4_sleep_action = reg4_sleep_action;
    next_reg4_sleep_source_sel = reg4_sleep_source_sel;
    next_reg4_sleep_voltage_code = reg4_sleep_voltage_code;
    next_fault_mask = fault_mask;
    next_trim_fuse_current_enable = trim_fuse_current_enable;
    next_rdata = rdata;
    if (WR_EN_IN) begin
      if (ADDR_IN == RLF_ADDR_REG4_LP) begin
        next_reg4_sleep_action = rlf_action_t'(WDATA_IN[RLF_ACT_LSB +: 2]);
        next_reg4_sleep_source_sel = rlf_source_t'(WDATA_IN[RLF_SRC_LSB +: 2]);
        next_reg4_sleep_voltage_code = WDATA_IN[RLF_VCODE_LSB +: 5];
      end else if (ADDR_IN == RLF_ADDR_FAULT_MASK) begin
        next_fault_mask = WDATA_IN & RLF_MASK_BITS;
      end else if (ADDR_IN == RLF_ADDR_FUSE_CTRL) begin
        next_trim_fuse_current_enable = WDATA_IN[RLF_FUSE_BIT];
      end
    end
    if (RD_EN_IN) begin
      next_rdata = 16'h0000;
      if (ADDR_IN == RLF_ADDR_REG4_LP) begin
        next_rdata[RLF_ACT_LSB +: 2] = reg4_sleep_action;
        next_rdata[RLF_SRC_LSB +: 2] = reg4_sleep_source_sel;
        next_rdata[RLF_VCODE_LSB +: 5] = reg4_sleep_voltage_code;
      end else if (ADDR_IN == RLF_ADDR_FAULT_MASK) begin
        next_rdata = fault_mask;
      end else if (ADDR_IN == RLF_ADDR_FUSE_CTRL) begin
        next_rdata[RLF_FUSE_BIT] = trim_fuse_current_enable;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      reg4_sleep_action <= rlf_action_t'(RLF_ACT_RST);
      reg4_sleep_source_sel <= rlf_source_t'(RLF_SRC_RST);
      reg4_sleep_voltage_code <= RLF_VCODE_RST;
      fault_mask <= RLF_MASK_RST;
      trim_fuse_current_enable <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      reg4_sleep_action <= next_reg4_sleep_action;
      reg4_sleep_source_sel <= next_reg4_sleep_source_sel;
      reg4_sleep_voltage_code <= next_reg4_sleep_voltage_code;
      fault_mask <= next_fault_mask;
      trim_fuse_current_enable <= next_trim_fuse_current_enable;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  logic next_sleep, next_fault_n;
  logic [14:0] masked;
  always_comb begin
    case (reg4_sleep_source_sel)
      RLF_SRC_REGBIT: next_sleep = src_reg;
      RLF_SRC_LINE1: next_sleep = src_l1;
      RLF_SRC_LINE2: next_sleep = src_l2;
      default: next_sleep = src_l3;
    endcase
    masked = '0;
    masked[14] = ls_flt & ~fault_mask[RLF_LS_BIT];
    masked[13:10] = ldo_flt & ~fault_mask[RLF_LDO_LSB +: 4];
    masked[5:0] = dc_flt & ~fault_mask[RLF_DC_LSB +: 6];
    next_fault_n = ~(|masked);
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      REG4_SLEEP_OUT <= 1'b0;
      REG4_SLEEP_DISABLE_OUT <= 1'b0;
      REG4_SLEEP_IMAGE_OUT <= 1'b0;
      REG4_SLEEP_VOLTAGE_CODE_OUT <= RLF_VCODE_RST;
      REG4_IMAGE_MV_OUT <= 12'h000;
      SUPPLY_FAULT_N_OUT <= 1'b1;
      TRIM_FUSE_CURRENT_ENABLE_OUT <= 1'b0;
    end else begin
      REG4_SLEEP_OUT <= next_sleep;
      // action decode, reserved codes do nothing
      REG4_SLEEP_DISABLE_OUT <= next_sleep &&
                                reg4_sleep_action == RLF_ACT_DISABLE;
      REG4_SLEEP_IMAGE_OUT <= next_sleep && reg4_sleep_action == RLF_ACT_IMAGE;
      REG4_SLEEP_VOLTAGE_CODE_OUT <= reg4_sleep_voltage_code;
      REG4_IMAGE_MV_OUT <= code_to_mv(reg4_sleep_voltage_code);
      SUPPLY_FAULT_N_OUT <= next_fault_n;
      TRIM_FUSE_CURRENT_ENABLE_OUT <= trim_fuse_current_enable;
    end
  end

  assign RDATA_OUT = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence mask_write_s;
    WR_EN_IN && ADDR_IN == RLF_ADDR_FAULT_MASK;
  endsequence
  sequence read_lp_s;
    RD_EN_IN && ADDR_IN == RLF_ADDR_REG4_LP;
  endsequence
  sequence read_mask_s;
    RD_EN_IN && ADDR_IN == RLF_ADDR_FAULT_MASK;
  endsequence
  sequence read_fuse_s;
    RD_EN_IN && ADDR_IN == RLF_ADDR_FUSE_CTRL;
  endsequence
  sequence read_other_s;
    RD_EN_IN && ADDR_IN != RLF_ADDR_REG4_LP &&
    ADDR_IN != RLF_ADDR_FAULT_MASK && ADDR_IN != RLF_ADDR_FUSE_CTRL;
  endsequence
  sequence sel_regbit_s;
    reg4_sleep_source_sel == RLF_SRC_REGBIT;
  endsequence
  sequence sel_line1_s;
    reg4_sleep_source_sel == RLF_SRC_LINE1;
  endsequence
  sequence sel_line2_s;
    reg4_sleep_source_sel == RLF_SRC_LINE2;
  endsequence
  sequence sel_line3_s;
    reg4_sleep_source_sel == RLF_SRC_LINE3;
  endsequence

  unused_bits_zero_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (fault_mask & ~RLF_MASK_BITS) == 16'h0000)
    else $error("unused mask bits set");
  mask_reset_a: assert property (
    @(posedge REF_CLK_IN) RST_IN |=> fault_mask == RLF_MASK_RST)
    else $error("mask not cleared by reset");
  action_reset_a: assert property (
    @(posedge REF_CLK_IN) RST_IN |=> reg4_sleep_action == RLF_ACT_IMAGE &&
    reg4_sleep_source_sel == RLF_SRC_REGBIT)
    else $error("sleep fields not at default");
  ls_masked_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (fault_mask[RLF_LS_BIT] && ldo_flt == 4'h0 && dc_flt == 6'h00)
    |=> SUPPLY_FAULT_N_OUT)
    else $error("masked limit fault reached output");
  ldo_pass_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    |(ldo_flt & ~fault_mask[RLF_LDO_LSB +: 4]) |=> !SUPPLY_FAULT_N_OUT)
    else $error("unmasked regulator fault lost");
  dc_pass_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    |(dc_flt & ~fault_mask[RLF_DC_LSB +: 6]) |=> !SUPPLY_FAULT_N_OUT)
    else $error("unmasked converter fault lost");
  mask_write_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    mask_write_s |=> fault_mask == ($past(WDATA_IN) & RLF_MASK_BITS))
    else $error("mask write not stored");
  fuse_enable_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    (WR_EN_IN && ADDR_IN == RLF_ADDR_FUSE_CTRL)
    |=> ##1 TRIM_FUSE_CURRENT_ENABLE_OUT == $past(WDATA_IN[RLF_FUSE_BIT], 2))
    else $error("fuse enable not following write");
  disable_action_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    REG4_SLEEP_DISABLE_OUT |-> $past(reg4_sleep_action) == RLF_ACT_DISABLE)
    else $error("disable without disable action");
  voltage_map_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    reg4_sleep_voltage_code == 5'h1F && $stable(reg4_sleep_voltage_code)
    |=> REG4_IMAGE_MV_OUT == 12'hCE4)
    else $error("top code not 3300 mV");
  read_lowpower_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    read_lp_s |=> RDATA_OUT[RLF_ACT_LSB +: 2] == $past(reg4_sleep_action) &&
    RDATA_OUT[RLF_SRC_LSB +: 2] == $past(reg4_sleep_source_sel) &&
    RDATA_OUT[RLF_VCODE_LSB +: 5] == $past(reg4_sleep_voltage_code))
    else $error("sleep word read back wrong");
  read_mask_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    read_mask_s |=> RDATA_OUT == $past(fault_mask))
    else $error("mask word read back wrong");
  read_fuse_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    read_fuse_s |=> RDATA_OUT[RLF_FUSE_BIT] ==
    $past(trim_fuse_current_enable))
    else $error("fuse bit read back wrong");
  read_other_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    read_other_s |=> RDATA_OUT == 16'h0000)
    else $error("unmapped read not zero");
  sleep_regbit_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    sel_regbit_s |=> REG4_SLEEP_OUT == $past(src_reg))
    else $error("sleep not from register bit");
  sleep_line1_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    sel_line1_s |=> REG4_SLEEP_OUT == $past(src_l1))
    else $error("sleep not from line one");
  sleep_line2_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    sel_line2_s |=> REG4_SLEEP_OUT == $past(src_l2))
    else $error("sleep not from line two");
  sleep_line3_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    sel_line3_s |=> REG4_SLEEP_OUT == $past(src_l3))
    else $error("sleep not from line three");
  image_action_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    REG4_SLEEP_IMAGE_OUT |-> $past(reg4_sleep_action) == RLF_ACT_IMAGE)
    else $error("image without image action");
  reserved_quiet_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    reg4_sleep_action inside {RLF_ACT_RSVD2, RLF_ACT_RSVD3}
    |=> !REG4_SLEEP_DISABLE_OUT && !REG4_SLEEP_IMAGE_OUT)
    else $error("reserved action drove an output");
  voltage_bottom_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    reg4_sleep_voltage_code == 5'h00 |=> REG4_IMAGE_MV_OUT == 12'h384)
    else $error("bottom code not 900 mV");
  voltage_knee_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    reg4_sleep_voltage_code == 5'h10 |=> REG4_IMAGE_MV_OUT == 12'h708)
    else $error("knee code not 1800 mV");
  ls_pass_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    ls_flt && !fault_mask[RLF_LS_BIT] |=> !SUPPLY_FAULT_N_OUT)
    else $error("unmasked limit fault lost");
  fault_idle_a: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    !(ls_flt && !fault_mask[RLF_LS_BIT]) &&
    (ldo_flt & ~fault_mask[RLF_LDO_LSB +: 4]) == 4'h0 &&
    (dc_flt & ~fault_mask[RLF_DC_LSB +: 6]) == 6'h00 |=> SUPPLY_FAULT_N_OUT)
    else $error("fault output low with no unmasked fault");
  fuse_reset_a: assert property (
    @(posedge REF_CLK_IN) RST_IN |=> !trim_fuse_current_enable)
    else $error("fuse enable not cleared by reset");

endmodule

// ---- test/rlf_host.sv ----
// Host model: writes and reads words over the device register port.
// Assumes the device samples strobes on the rising clock edge.
`timescale 1ns/100ps
module rlf_host
  import rlf_pkg::*;
(
  // Clock and read data
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  // Request lines
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    // Released bus never shows a stale value
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask
  task automatic fuse_cycle(output logic [15:0] on, output logic [15:0] off);
    wr(RLF_ADDR_FUSE_CTRL, 16'h8000);
    rd(RLF_ADDR_FUSE_CTRL, on);
    wr(RLF_ADDR_FUSE_CTRL, 16'h0000);
    rd(RLF_ADDR_FUSE_CTRL, off);
  endtask
endmodule

// ---- test/tb_top.sv ----
// Bench for the regulator sleep, fault mask and fuse control words.
// Assumes host model drives the port; faults and lines come from here.
`timescale 1ns/100ps
module tb_top
  import rlf_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr, rd;
  logic [7:0] addr;
  logic [15:0] wd, rdat, d1, d2, b, flt = 16'h0000;
  logic [3:0] sl = 4'h0;
  logic [1:0] a, s;
  logic slp, dis, img, fn, fuse;
  logic [4:0] code;
  logic [11:0] mv;
  int errors = 0;
  int n_checks = 0;
  int i;
  always #50 clk = ~clk;
  rlf_host u_host(.clk_in(clk), .rdata_in(rdat), .wr_en_out(wr),
    .rd_en_out(rd), .addr_out(addr), .wdata_out(wd));
  rlf_regs u_rlf_regs(.REF_CLK_IN(clk), .RST_IN(rst), .WR_EN_IN(wr),
    .RD_EN_IN(rd), .ADDR_IN(addr), .WDATA_IN(wd), .RDATA_OUT(rdat),
    .SLEEP_REG_BIT_IN(sl[0]), .LOW_POWER_LINE_ONE_IN(sl[1]),
    .LOW_POWER_LINE_TWO_IN(sl[2]), .LOW_POWER_LINE_THREE_IN(sl[3]),
    .LIMIT_SWITCH_FAULT_IN(flt[15]), .LINEAR_REG_FAULT_IN(flt[11:8]),
    .CONVERTER_FAULT_IN(flt[5:0]), .REG4_SLEEP_OUT(slp),
    .REG4_SLEEP_DISABLE_OUT(dis), .REG4_SLEEP_IMAGE_OUT(img),
    .REG4_SLEEP_VOLTAGE_CODE_OUT(code), .REG4_IMAGE_MV_OUT(mv),
    .SUPPLY_FAULT_N_OUT(fn), .TRIM_FUSE_CURRENT_ENABLE_OUT(fuse));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      $display("unexpected at %0t got %h exp %h", $time, g, e);
      errors++;
    end
  endtask
  // Covers the 3 cycle sync and register latency
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic do_rst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic defaults();
    u_host.rd(RLF_ADDR_REG4_LP, d1);
    chk(d1, 16'h001C);
    u_host.rd(RLF_ADDR_FAULT_MASK, d1);
    chk(d1, 16'h0000);
    u_host.rd(RLF_ADDR_FUSE_CTRL, d1);
    chk(d1, 16'h0000);
    chk({15'h0000, fn}, 16'h0001);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 4000);
    errors++;
    test_done();
  end
  initial begin
    do_rst();
    defaults();
    $display("test defaults done");
    u_host.wr(RLF_ADDR_FAULT_MASK, 16'hFFFF);
    u_host.rd(RLF_ADDR_FAULT_MASK, d1);
    chk(d1, 16'h8F3F);
    u_host.rd(8'hD4, d1);
    chk(d1, 16'h0000);
    for (i = 0; i < 16; i++) begin
      if (RLF_MASK_BITS[i]) begin
        b = 16'h0001 << i;
        u_host.wr(RLF_ADDR_FAULT_MASK, RLF_MASK_BITS & ~b);
        flt <= b;
        settle();
        chk({15'h0000, fn}, 16'h0000);
        u_host.wr(RLF_ADDR_FAULT_MASK, b);
        settle();
        chk({15'h0000, fn}, 16'h0001);
      end
    end
    flt <= 16'h0000;
    $display("test masks done");
    for (i = 0; i < 16; i++) begin
      a = 2'(i >> 2);
      s = 2'(i);
      u_host.wr(RLF_ADDR_REG4_LP, {2'h0, a, 2'h0, s, 8'h1C});
      sl <= 4'h1 << s;
      settle();
      chk({13'h0000, slp, dis, img}, {13'h0000, 1'b1, a == 2'h1,
        a == 2'h0});
    end
    $display("test sleep done");
    for (i = 0; i < 32; i++) begin
      u_host.wr(RLF_ADDR_REG4_LP, 16'(i));
      settle();
      chk({11'h000, code}, 16'(i));
      chk({4'h0, mv}, 16'(i > 15 ? 200 + i * 100 : 900 + i * 50));
    end
    $display("test voltage done");
    u_host.wr(RLF_ADDR_FUSE_CTRL, 16'h8000);
    settle();
    chk({15'h0000, fuse}, 16'h0001);
    u_host.fuse_cycle(d1, d2);
    chk(d1, 16'h8000);
    chk(d2, 16'h0000);
    chk({15'h0000, fuse}, 16'h0000);
    $display("test fuse done");
    u_host.wr(RLF_ADDR_REG4_LP, 16'h3318);
    u_host.wr(RLF_ADDR_FAULT_MASK, 16'h8F3F);
    u_host.wr(RLF_ADDR_FUSE_CTRL, 16'h8000);
    do_rst();
    defaults();
    $display("test midrun reset done");
    test_done();
  end
endmodule
